//--- logic/melody_pkg.sv
// Constants and types shared by the melody tone timer
package melody_pkg;

   // Register word index, taken from wb_adr_i[4:2]
   localparam logic [2:0] ADR_TONE_SEL   = 3'h0;
   localparam logic [2:0] ADR_TIM_CTRL   = 3'h1;
   localparam logic [2:0] ADR_TIM_PERIOD = 3'h2;
   localparam logic [2:0] ADR_IRQ_REQ    = 3'h3;
   localparam logic [2:0] ADR_IRQ_MASK   = 3'h4;

   // Field positions
   localparam int TONE_HIZ_BIT   = 3;
   localparam int TONE_CODE_MSB  = 2;
   localparam int CTRL_FLAG_BIT  = 3;
   localparam int CTRL_AUTO_BIT  = 2;
   localparam int CTRL_SEL_HI    = 1;
   localparam int CTRL_SEL_LO    = 0;
   localparam int IRQ_FLAG_BIT   = 0;
   localparam int IRQ_MASK_BIT   = 0;

   // Reset values
   localparam logic [3:0] TONE_SEL_RESET = 4'h8;
   localparam logic [1:0] TICK_SEL_RESET = 2'h0;
   localparam logic [3:0] PERIOD_RESET   = 4'h0;
   localparam logic [3:0] COUNT_ZERO     = 4'h0;
   localparam logic [3:0] COUNT_ONE      = 4'h1;
   localparam logic       IRQ_MASK_RESET = 1'h1;

   // Prescaler tap index for each tick select code
   localparam logic [2:0] TAP_SEL_0 = 3'h3;
   localparam logic [2:0] TAP_SEL_1 = 3'h5;
   localparam logic [2:0] TAP_SEL_2 = 3'h7;
   localparam logic [2:0] TAP_SEL_3 = 3'h1;

   // Tone codes and half periods in system clocks
   localparam logic [2:0] TONE_SILENT = 3'h0;
   localparam logic [3:0] HALF_DIV_1  = 4'h4;
   localparam logic [3:0] HALF_DIV_2  = 4'h5;
   localparam logic [3:0] HALF_DIV_3  = 4'h6;
   localparam logic [3:0] HALF_DIV_4  = 4'h7;
   localparam logic [3:0] HALF_DIV_5  = 4'h8;
   localparam logic [3:0] HALF_DIV_6  = 4'hA;
   localparam logic [3:0] HALF_DIV_7  = 4'hC;

   typedef enum logic [1:0] {T_IDLE, T_ARMED, T_RUN} timer_state_type;

endpackage : melody_pkg

//--- logic/tone_divider.sv
// Square wave tone generator dividing the system clock
`timescale 1ns/10ps
module tone_divider
   import melody_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic [2:0] tone_code_i,
   input  wire logic       active_i,
   // Tone
   output logic            tone_o
);

   logic [3:0] half_len;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       wave_q;
   logic       wave_d;

   always_comb begin
      case (tone_code_i)
         3'h1:    half_len = HALF_DIV_1;
         3'h2:    half_len = HALF_DIV_2;
         3'h3:    half_len = HALF_DIV_3;
         3'h4:    half_len = HALF_DIV_4;
         3'h5:    half_len = HALF_DIV_5;
         3'h6:    half_len = HALF_DIV_6;
         3'h7:    half_len = HALF_DIV_7;
         default: half_len = HALF_DIV_1;
      endcase
   end

   // Equal high and low halves
   always_comb begin
      cnt_d  = cnt_q;
      wave_d = wave_q;
      if (!active_i || tone_code_i == TONE_SILENT) begin
         cnt_d  = COUNT_ZERO;
         wave_d = 1'b0;
      end else if (cnt_q == half_len - COUNT_ONE) begin
         cnt_d  = COUNT_ZERO;
         wave_d = ~wave_q;
      end else begin
         cnt_d = cnt_q + COUNT_ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q  <= COUNT_ZERO;
         wave_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         wave_q <= wave_d;
      end
   end

   assign tone_o = wave_q;

   chk_silence_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (!active_i || tone_code_i == TONE_SILENT) |=> !tone_o)
      else $error("tone not low while silent");

   chk_half_period: assert property (@(posedge clk_i) disable iff (rst_i)
      (active_i && tone_code_i == 3'h1 && $rose(tone_o)) ##1
      (active_i && tone_code_i == 3'h1) [*2] |=> tone_o)
      else $error("tone half period too short");

endmodule : tone_divider

//--- logic/melody_tone_timer.sv
// Melody tone generator with 4-bit timer behind a Wishbone slave
`timescale 1ns/10ps
module melody_tone_timer
   import melody_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:2]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Prescaler taps
   input  wire logic [7:0]  presc_taps_i,
   // Tone pin and interrupt
   output logic             tone_pin_o,
   output logic             tone_pin_oe_o,
   output logic             tone_timer_irq_o
);

   // Bus state
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;
   logic        req;
   logic        wr;
   logic        wr_tone;
   logic        wr_ctrl;
   logic        wr_period;
   logic        wr_irq;
   logic        wr_mask;
   logic [3:0]  wdat;

   // Register fields
   logic [3:0]  tone_sel_q;
   logic [3:0]  tone_sel_d;
   logic        auto_q;
   logic        auto_d;
   logic [1:0]  tick_sel_q;
   logic [1:0]  tick_sel_d;
   logic        manual_q;
   logic        manual_d;
   logic [3:0]  period_q;
   logic [3:0]  period_d;
   logic        irq_flag_q;
   logic        irq_flag_d;
   logic        irq_mask_q;
   logic        irq_mask_d;

   // Timer state
   timer_state_type state_q;
   timer_state_type state_d;
   logic [3:0]  count_q;
   logic [3:0]  count_d;
   logic        extra_q;
   logic        extra_d;
   logic        tap_now;
   logic        tap_prev_q;
   logic        tick;
   logic        zero_evt;
   logic        timer_on;
   logic        tone_active;
   logic        tone_wave;

   // Bus decode; a write takes effect on the edge where ack is high
   assign req       = wb_cyc_i && wb_stb_i;
   assign wr        = req && wb_we_i && ack_q && wb_sel_i[0];
   assign wr_tone   = wr && wb_adr_i == ADR_TONE_SEL;
   assign wr_ctrl   = wr && wb_adr_i == ADR_TIM_CTRL;
   assign wr_period = wr && wb_adr_i == ADR_TIM_PERIOD;
   assign wr_irq    = wr && wb_adr_i == ADR_IRQ_REQ;
   assign wr_mask   = wr && wb_adr_i == ADR_IRQ_MASK;
   assign wdat      = wb_dat_i[3:0];

   // Tick source
   always_comb begin
      case (tick_sel_q)
         2'h0:    tap_now = presc_taps_i[TAP_SEL_0];
         2'h1:    tap_now = presc_taps_i[TAP_SEL_1];
         2'h2:    tap_now = presc_taps_i[TAP_SEL_2];
         2'h3:    tap_now = presc_taps_i[TAP_SEL_3];
         default: tap_now = presc_taps_i[TAP_SEL_0];
      endcase
   end

   assign tick        = tap_now && !tap_prev_q;
   assign timer_on    = state_q == T_RUN;
   assign tone_active = timer_on || manual_q;

   // Bus answer: ack one cycle after request, read data with it
   always_comb begin
      ack_d  = req && !ack_q;
      rdat_d = rdat_q;
      if (req && !ack_q) begin
         rdat_d = '0;
         case (wb_adr_i)
            ADR_TONE_SEL: rdat_d[3:0] = tone_sel_q;
            ADR_TIM_CTRL: rdat_d[3:0] = {tone_active, auto_q, tick_sel_q};
            ADR_IRQ_REQ:  rdat_d[IRQ_FLAG_BIT] = irq_flag_q;
            ADR_IRQ_MASK: rdat_d[IRQ_MASK_BIT] = irq_mask_q;
            default:      rdat_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // Register fields and timer
   always_comb begin
      tone_sel_d = tone_sel_q;
      auto_d     = auto_q;
      tick_sel_d = tick_sel_q;
      manual_d   = manual_q;
      period_d   = period_q;
      irq_mask_d = irq_mask_q;
      state_d    = state_q;
      count_d    = count_q;
      extra_d    = extra_q;
      zero_evt   = 1'b0;
      if (wr_tone) begin
         tone_sel_d = wdat;
      end
      if (wr_mask) begin
         irq_mask_d = wdat[IRQ_MASK_BIT];
      end
      if (wr_ctrl) begin
         auto_d     = wdat[CTRL_AUTO_BIT];
         tick_sel_d = wdat[CTRL_SEL_HI:CTRL_SEL_LO];
         manual_d   = wdat[CTRL_FLAG_BIT];
      end
      case (state_q)
         T_IDLE: begin
            extra_d = 1'b0;
         end
         T_ARMED: begin
            if (tick) begin
               count_d = period_q;
               state_d = T_RUN;
            end
         end
         T_RUN: begin
            if (tick) begin
               if (count_q == COUNT_ONE && extra_q) begin
                  extra_d = 1'b0;
               end else if (count_q == COUNT_ONE) begin
                  zero_evt = 1'b1;
                  if (auto_q) begin
                     count_d = period_q;
                  end else begin
                     count_d = COUNT_ZERO;
                     state_d = T_IDLE;
                  end
               end else begin
                  count_d = count_q - COUNT_ONE;
               end
            end
         end
         default: begin
            state_d = T_IDLE;
         end
      endcase
      // Leaving continuous mode mid-run stretches the last lap by one tick
      if (wr_ctrl && auto_q && !wdat[CTRL_AUTO_BIT] && timer_on) begin
         extra_d = 1'b1;
      end
      // Mode bit set starts the tone without waiting for a tick
      if (wr_ctrl && wdat[CTRL_AUTO_BIT] && !auto_q && !timer_on
          && period_q != COUNT_ZERO) begin
         count_d = period_q;
         state_d = T_RUN;
         extra_d = 1'b0;
      end
      if (wr_period) begin
         period_d = wdat;
         if (wdat == COUNT_ZERO) begin
            state_d  = T_IDLE;
            count_d  = COUNT_ZERO;
            auto_d   = 1'b0;
            extra_d  = 1'b0;
            zero_evt = 1'b0;
         end else if (!(timer_on && auto_q)) begin
            state_d = T_ARMED;
            extra_d = 1'b0;
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_comb begin
      irq_flag_d = irq_flag_q;
      if (wr_irq && wdat[IRQ_FLAG_BIT]) begin
         irq_flag_d = 1'b0;
      end
      if (zero_evt) begin
         irq_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tone_sel_q <= TONE_SEL_RESET;
         auto_q     <= 1'b0;
         tick_sel_q <= TICK_SEL_RESET;
         manual_q   <= 1'b0;
         period_q   <= PERIOD_RESET;
         irq_flag_q <= 1'b0;
         irq_mask_q <= IRQ_MASK_RESET;
         state_q    <= T_IDLE;
         count_q    <= COUNT_ZERO;
         extra_q    <= 1'b0;
         tap_prev_q <= 1'b0;
      end else begin
         tone_sel_q <= tone_sel_d;
         auto_q     <= auto_d;
         tick_sel_q <= tick_sel_d;
         manual_q   <= manual_d;
         period_q   <= period_d;
         irq_flag_q <= irq_flag_d;
         irq_mask_q <= irq_mask_d;
         state_q    <= state_d;
         count_q    <= count_d;
         extra_q    <= extra_d;
         tap_prev_q <= tap_now;
      end
   end

   tone_divider u_tone (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .tone_code_i (tone_sel_q[TONE_CODE_MSB:0]),
      .active_i    (tone_active),
      .tone_o      (tone_wave)
   );

   assign wb_ack_o         = ack_q;
   assign wb_dat_o         = rdat_q;
   assign tone_pin_o       = tone_wave;
   assign tone_pin_oe_o    = !tone_sel_q[TONE_HIZ_BIT];
   assign tone_timer_irq_o = irq_flag_q && !irq_mask_q;

   chk_zero_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      zero_evt |=> irq_flag_q)
      else $error("zero reached but request flag not set");

   chk_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      (zero_evt && irq_mask_q && !wr_mask) |=> !tone_timer_irq_o)
      else $error("interrupt line high while masked");

   chk_irq_unmasked: assert property (@(posedge clk_i) disable iff (rst_i)
      (zero_evt && !irq_mask_q && !wr_mask) |=> tone_timer_irq_o)
      else $error("unmasked request did not reach interrupt line");

   chk_zero_period_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_period && wdat == COUNT_ZERO && !irq_flag_q)
      |=> (state_q == T_IDLE && !auto_q && !irq_flag_q))
      else $error("period zero write did not stop quietly");

   chk_single_run_end: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_on && tick && count_q == COUNT_ONE && !extra_q && !auto_q
       && !wr_period && !wr_ctrl) |=> (state_q == T_IDLE && irq_flag_q))
      else $error("single run did not stop with request");

   chk_armed_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == T_ARMED && tick && !wr_period && !wr_ctrl)
      |=> (timer_on && count_q == $past(period_q)))
      else $error("timer did not start on tick after load");

   chk_auto_reload: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_on && tick && count_q == COUNT_ONE && !extra_q && auto_q
       && !wr_period && !wr_ctrl) |=> (timer_on && count_q == $past(period_q)))
      else $error("continuous mode did not reload");

   chk_last_lap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_on && tick && count_q == COUNT_ONE && extra_q && !wr_period)
      |=> (timer_on && count_q == COUNT_ONE && !extra_q))
      else $error("last lap not stretched by one tick");

   chk_auto_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && wdat[CTRL_AUTO_BIT] && !auto_q && !timer_on
       && period_q != COUNT_ZERO) |=> tone_active)
      else $error("setting mode bit did not start tone");

   chk_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_on && tick && count_q > COUNT_ONE && !wr_period && !wr_ctrl)
      |=> count_q == $past(count_q) - COUNT_ONE)
      else $error("count did not step down by one");

   chk_hold_no_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      (timer_on && !tick && !wr_period && !wr_ctrl) |=> $stable(count_q))
      else $error("count moved without a tick");

   chk_hiz_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (!tone_pin_oe_o && !tone_pin_o && tick_sel_q == TICK_SEL_RESET))
      else $error("pin not quiet after reset");

   chk_manual_tone: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ctrl && wdat[CTRL_FLAG_BIT]) |=> tone_active)
      else $error("manual switch did not start tone");

   chk_flag_readback: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !ack_q && wb_adr_i == ADR_TIM_CTRL)
      |=> (wb_dat_o[CTRL_FLAG_BIT] == $past(tone_active)))
      else $error("control read does not show tone active flag");

   chk_period_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !ack_q && wb_adr_i == ADR_TIM_PERIOD) |=> (wb_dat_o == 32'h0))
      else $error("write only period read back nonzero");

endmodule : melody_tone_timer

//--- tb/buzzer_model.sv
// Piezo buzzer model that measures the tone on the pin
`timescale 1ns/10ps
module buzzer_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Tone pin
   input  wire logic        pin_i,
   input  wire logic        oe_i,
   // Observations
   output logic [31:0]      rise_count_o,
   output logic [31:0]      rise_gap_o
);
   logic        level_q;
   logic [31:0] since_q;
   logic        wire_lv;

   // Floating pin shows a level that changes every cycle
   assign wire_lv = oe_i ? pin_i : ~level_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= 1'b0;
         since_q <= 32'h0;
         rise_count_o <= 32'h0;
         rise_gap_o <= 32'h0;
      end else begin
         level_q <= wire_lv;
         since_q <= since_q + 32'h1;
         if (oe_i && wire_lv && !level_q) begin
            rise_count_o <= rise_count_o + 32'h1;
            rise_gap_o <= since_q;
            since_q <= 32'h1;
         end
      end
   end
endmodule : buzzer_model

//--- tb/test_melody_tone_timer.sv
// Self-checking bench for the melody tone timer
`timescale 1ns/10ps
module test_melody_tone_timer
   import melody_pkg::*;
;
   typedef struct {
      logic [2:0] code;
      logic [1:0] sel;
      logic [3:0] per;
   } row_type;

   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [4:2]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [7:0]  presc_taps_i = 8'h00;
   logic        tone_pin_o;
   logic        tone_pin_oe_o;
   logic        tone_timer_irq_o;
   logic [31:0] rise_count;
   logic [31:0] rise_gap;
   logic [31:0] r0;
   int          fail_count;
   int          n_compared;
   int          cyc_n = 0;
   int          n;
   int          t;
   int          t1;
   int          half_tab [8] = '{0, 4, 5, 6, 7, 8, 10, 12};
   int          tap_tab [4]  = '{3, 5, 7, 1};
   row_type     rows [8];

   melody_tone_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .presc_taps_i(presc_taps_i), .tone_pin_o(tone_pin_o),
      .tone_pin_oe_o(tone_pin_oe_o), .tone_timer_irq_o(tone_timer_irq_o));

   buzzer_model partner (.clk_i(clk_i), .rst_i(rst_i), .pin_i(tone_pin_o),
      .oe_i(tone_pin_oe_o), .rise_count_o(rise_count), .rise_gap_o(rise_gap));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Free running prescaler taps and hang guard
   always @(posedge clk_i) begin
      presc_taps_i <= presc_taps_i + 8'h01;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wb_cycle(input logic w, input logic [2:0] a, input logic [3:0] d,
                           output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {28'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      // Let the write settle before anyone samples the outputs
      @(posedge clk_i);
      chk({31'h0, k < 50}, 32'h1);
   endtask : wb_cycle

   task automatic wr(input logic [2:0] a, input logic [3:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, a, 4'h0, q);
      chk(q, exp);
   endtask : rd

   task automatic wait_irq(output int m);
      m = 0;
      do begin
         @(posedge clk_i);
         m++;
      end while (!(tone_timer_irq_o === 1'b1 && m > 2) && m < 2000);
      chk({31'h0, m < 2000}, 32'h1);
   endtask : wait_irq

   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 3'h0;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      fail_count = 0;
      n_compared = 0;
      rows = '{'{3'h0, 2'h3, 4'h4}, '{3'h1, 2'h0, 4'h2}, '{3'h2, 2'h1, 4'h1},
               '{3'h3, 2'h2, 4'h1}, '{3'h4, 2'h3, 4'hF}, '{3'h5, 2'h0, 4'h2},
               '{3'h6, 2'h1, 4'h2}, '{3'h7, 2'h0, 4'h3}};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, tone_pin_oe_o}, 32'h0);
      rd(ADR_TONE_SEL, {28'h0, TONE_SEL_RESET});
      rd(ADR_TIM_CTRL, 32'h0);
      rd(ADR_IRQ_MASK, 32'h1);
      rd(3'h5, 32'h0);
      wr(ADR_TIM_PERIOD, 4'h9);
      rd(ADR_TIM_PERIOD, 32'h0);
      wr(ADR_TIM_PERIOD, 4'h0);
      wr(ADR_IRQ_REQ, 4'h1);
      wr(ADR_IRQ_MASK, 4'h0);
      // Table of single runs over every tone code and tick select
      for (int i = 0; i < 8; i++) begin
         wr(ADR_TONE_SEL, {1'b0, rows[i].code});
         chk({31'h0, tone_pin_oe_o}, 32'h1);
         wr(ADR_TIM_CTRL, {2'b00, rows[i].sel});
         r0 = rise_count;
         wr(ADR_TIM_PERIOD, rows[i].per);
         t = 1 << (tap_tab[rows[i].sel] + 1);
         wait_irq(n);
         chk({31'h0, n >= int'(rows[i].per) * t && n <= (int'(rows[i].per) + 1) * t + 6},
             32'h1);
         rd(ADR_TIM_CTRL, {30'h0, rows[i].sel});
         rd(ADR_IRQ_REQ, 32'h1);
         if (rows[i].code == TONE_SILENT) begin
            chk(rise_count - r0, 32'h0);
         end else begin
            chk(rise_gap, 32'(2 * half_tab[rows[i].code]));
         end
         wr(ADR_IRQ_REQ, 4'h1);
      end
      // Masked request still sets the flag
      wr(ADR_IRQ_MASK, 4'h1);
      wr(ADR_TIM_CTRL, 4'h3);
      wr(ADR_TIM_PERIOD, 4'h1);
      repeat (40) @(posedge clk_i);
      chk({31'h0, tone_timer_irq_o}, 32'h0);
      rd(ADR_IRQ_REQ, 32'h1);
      wr(ADR_IRQ_REQ, 4'h1);
      rd(ADR_IRQ_REQ, 32'h0);
      wr(ADR_IRQ_MASK, 4'h0);
      // Period zero in mid-run
      wr(ADR_TIM_CTRL, 4'h0);
      wr(ADR_TIM_PERIOD, 4'h5);
      repeat (20) @(posedge clk_i);
      wr(ADR_TIM_PERIOD, 4'h0);
      rd(ADR_TIM_CTRL, 32'h0);
      repeat (150) @(posedge clk_i);
      rd(ADR_IRQ_REQ, 32'h0);
      // Continuous run, then leave it by clearing the mode bit
      wr(ADR_TIM_PERIOD, 4'h2);
      wr(ADR_TIM_CTRL, 4'h4);
      rd(ADR_TIM_CTRL, 32'hC);
      wait_irq(n);
      t1 = cyc_n;
      wr(ADR_IRQ_REQ, 4'h1);
      wait_irq(n);
      chk(32'(cyc_n - t1), 32'h20);
      t1 = cyc_n;
      wr(ADR_IRQ_REQ, 4'h1);
      wr(ADR_TIM_CTRL, 4'h0);
      wait_irq(n);
      chk(32'(cyc_n - t1), 32'h30);
      wr(ADR_IRQ_REQ, 4'h1);
      repeat (100) @(posedge clk_i);
      rd(ADR_IRQ_REQ, 32'h0);
      rd(ADR_TIM_CTRL, 32'h0);
      // Continuous run stopped by period zero
      wr(ADR_TIM_PERIOD, 4'h2);
      wr(ADR_TIM_CTRL, 4'h4);
      wait_irq(n);
      wr(ADR_IRQ_REQ, 4'h1);
      wr(ADR_TIM_PERIOD, 4'h0);
      rd(ADR_TIM_CTRL, 32'h0);
      repeat (100) @(posedge clk_i);
      rd(ADR_IRQ_REQ, 32'h0);
      // Manual tone switch and high impedance
      wr(ADR_TONE_SEL, 4'h1);
      wr(ADR_TIM_CTRL, 4'h8);
      repeat (40) @(posedge clk_i);
      rd(ADR_TIM_CTRL, 32'h8);
      chk(rise_gap, 32'h8);
      wr(ADR_TONE_SEL, 4'h9);
      chk({31'h0, tone_pin_oe_o}, 32'h0);
      wr(ADR_TONE_SEL, 4'h1);
      wr(ADR_TIM_CTRL, 4'h0);
      rd(ADR_TIM_CTRL, 32'h0);
      r0 = rise_count;
      repeat (30) @(posedge clk_i);
      chk(rise_count - r0, 32'h0);
      chk({31'h0, tone_pin_o}, 32'h0);
      // Reset in mid-tone quiets the pin and returns tone select and control to their reset values
      wr(ADR_TIM_CTRL, 4'h8);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, tone_pin_oe_o}, 32'h0);
      chk({31'h0, tone_pin_o}, 32'h0);
      rd(ADR_TONE_SEL, {28'h0, TONE_SEL_RESET});
      rd(ADR_TIM_CTRL, 32'h0);
      tally_and_finish();
   end
endmodule : test_melody_tone_timer
